// file: src/wiper_pkg.sv
// Constants and carrier types for the quad wiper command decoder
package wiper_pkg;
  localparam int CLK_MHZ = 10;
  // Longest stored-setting access, in microseconds
  localparam int BUSY_TIME_US = 2000;
  localparam int BUSY_CYCLES_DEF = BUSY_TIME_US * CLK_MHZ;
  localparam logic [4:0] FRAME_BITS = 5'h18;
  localparam logic [4:0] BITCNT_MAX = 5'h1f;
  localparam logic [7:0] WIPER_MAX = 8'hff;
  localparam logic [7:0] WIPER_MIN = 8'h00;
  localparam logic [8:0] ERASED_WORD = 9'h000;
  localparam logic [8:0] READ_RST = 9'h000;
  localparam logic [23:0] SHIFT_RST = 24'h000000;
  localparam logic [14:0] OUT_PAD = 15'h0000;
  localparam logic [15:0] BUSY_RST = 16'h0000;

  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_RD_WIPER = 4'hc;
  localparam logic [3:0] OP_WR_WIPER = 4'h4;
  localparam logic [3:0] OP_RD_STORE = 4'ha;
  localparam logic [3:0] OP_PROGRAM = 4'h2;
  localparam logic [3:0] OP_RESTORE = 4'hb;
  localparam logic [3:0] OP_SAVE = 4'h3;
  localparam logic [3:0] OP_INC = 4'h7;
  localparam logic [3:0] OP_DEC = 4'hf;
  localparam logic [3:0] OP_SLEEP = 4'h8;
  localparam logic [3:0] OP_WAKE = 4'h1;
  localparam logic [3:0] OP_ERASE = 4'hd;
  localparam logic [3:0] OP_SWRESET = 4'h9;

  // One 24-bit frame, most significant bit first on the wire
  typedef struct packed {
    logic [3:0] opcode_field;
    logic slot_select_hi;
    logic slot_select_lo;
    logic channel_select_hi;
    logic channel_select_lo;
    logic [6:0] unused_bits;
    logic buffer_mode_bit;
    logic [7:0] wiper_value_bits;
  } frame_t;

  // One channel's live setting; buffer mode 1 means buffer on
  typedef struct packed {
    logic buffer_mode_bit;
    logic [7:0] wiper_position_reg;
  } chan_t;

  localparam chan_t CHAN_RST = '{buffer_mode_bit: 1'b0, wiper_position_reg: 8'h00};
endpackage

// file: src/quad_wiper_command_decoder.sv
// Serial command decoder for a four-channel wiper with stored settings
`timescale 1ns/1ns
module quad_wiper_command_decoder
  import wiper_pkg::*;
#(
  parameter int BUSY_CYCLES = BUSY_CYCLES_DEF
)(
  input wire logic clk,
  input wire logic nrst,
  input wire logic spi_clk,
  input wire logic spi_cs_n,
  input wire logic spi_sdi,
  input wire logic wp_n,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  output logic ready_busy,
  output logic asleep,
  output chan_t [3:0] chan_out
);
  localparam logic [15:0] BUSY_LAST = 16'(BUSY_CYCLES - 1);

  typedef enum logic [1:0] {ST_INIT, ST_IDLE, ST_BUSY} state_t;

  function automatic logic [3:0] addr_of(input frame_t f);
    addr_of = {f.slot_select_hi, f.slot_select_lo, f.channel_select_hi, f.channel_select_lo};
  endfunction

  function automatic logic [7:0] step(input logic [7:0] v, input logic up);
    if (up)
      step = (v == WIPER_MAX) ? v : 8'(v + 8'h01);
    else
      step = (v == WIPER_MIN) ? v : 8'(v - 8'h01);
  endfunction

  // Reset release and pin synchronisers
  logic rst_m, rst_n;
  logic sclk_m, sclk_s, sclk_p, cs_m, cs_s, cs_p, sdi_m, sdi_s, wp_m, wp_s;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_m <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_m <= 1'b1;
      rst_n <= rst_m;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {sclk_m, sclk_s, sclk_p} <= 3'h0;
      {cs_m, cs_s, cs_p} <= 3'h7;
      {sdi_m, sdi_s, wp_m, wp_s} <= 4'h3;
    end
    else
    begin
      sclk_m <= spi_clk;
      sclk_s <= sclk_m;
      sclk_p <= sclk_s;
      cs_m <= spi_cs_n;
      cs_s <= cs_m;
      cs_p <= cs_s;
      sdi_m <= spi_sdi;
      sdi_s <= sdi_m;
      wp_m <= wp_n;
      wp_s <= wp_m;
    end
  end

  logic sclk_rise, sclk_fall, cs_fall, cs_rise;
  assign sclk_rise = sclk_s & ~sclk_p;
  assign sclk_fall = ~sclk_s & sclk_p;
  assign cs_fall = ~cs_s & cs_p;
  assign cs_rise = cs_s & ~cs_p;

  // Frame capture and read-back shifting
  logic [23:0] shift_q, shift_d, out_q, out_d;
  logic [4:0] bitcnt_q, bitcnt_d;
  logic sdo_q, sdo_d, oe_q, oe_d;
  logic [8:0] rdata_q, rdata_d;

  always_comb
  begin
    shift_d = shift_q;
    bitcnt_d = bitcnt_q;
    out_d = out_q;
    if (cs_fall)
    begin
      bitcnt_d = 5'h00;
      out_d = {OUT_PAD, rdata_q};
    end
    else if (!cs_s && sclk_rise)
    begin
      shift_d = {shift_q[22:0], sdi_s};
      if (bitcnt_q != BITCNT_MAX)
        bitcnt_d = 5'(bitcnt_q + 5'h01);
    end
    else if (!cs_s && sclk_fall)
      out_d = {out_q[22:0], 1'b0};
    sdo_d = out_d[23];
    oe_d = ~cs_s;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shift_q <= SHIFT_RST;
      bitcnt_q <= 5'h00;
      out_q <= SHIFT_RST;
      sdo_q <= 1'b0;
      oe_q <= 1'b0;
    end
    else
    begin
      shift_q <= shift_d;
      bitcnt_q <= bitcnt_d;
      out_q <= out_d;
      sdo_q <= sdo_d;
      oe_q <= oe_d;
    end
  end

  // Only an exact 24-clock frame is carried out
  logic exec;
  frame_t cmd;
  logic [3:0] addr;
  logic [1:0] ch;
  assign exec = cs_rise && (bitcnt_q == FRAME_BITS);
  assign cmd = frame_t'(shift_q);
  assign addr = addr_of(cmd);
  assign ch = addr[1:0];

  // Command execution
  state_t state_q, state_d;
  logic asleep_q, asleep_d, ready_q, ready_d;
  logic [15:0] busy_q, busy_d;
  chan_t [3:0] chan_q, chan_d;
  logic [8:0] store_q [16];
  logic [8:0] store_d [16];
  logic act;
  assign act = exec && (state_q == ST_IDLE) && !asleep_q;
  logic [7:0] cur_wiper;
  assign cur_wiper = chan_q[ch].wiper_position_reg;

  always_comb
  begin
    state_d = state_q;
    asleep_d = asleep_q;
    busy_d = busy_q;
    chan_d = chan_q;
    store_d = store_q;
    rdata_d = rdata_q;
    case (state_q)
      ST_INIT:
      begin
        for (int i = 0; i < 4; i++)
          chan_d[i] = chan_t'(store_q[i]);
        state_d = ST_IDLE;
      end
      ST_IDLE:
      begin
        if (exec && asleep_q)
        begin
          if (cmd.opcode_field == OP_WAKE)
            asleep_d = 1'b0;
        end
        else if (exec)
        begin
          busy_d = BUSY_RST;
          case (cmd.opcode_field)
            OP_RD_WIPER:
            begin
              rdata_d = chan_q[ch];
              state_d = ST_BUSY;
            end
            OP_WR_WIPER: chan_d[ch].wiper_position_reg = cmd.wiper_value_bits;
            OP_RD_STORE:
            begin
              rdata_d = store_q[addr];
              state_d = ST_BUSY;
            end
            OP_PROGRAM:
            begin
              if (wp_s)
                store_d[addr] = {cmd.buffer_mode_bit, cmd.wiper_value_bits};
              state_d = ST_BUSY;
            end
            OP_RESTORE:
            begin
              chan_d[ch] = chan_t'(store_q[addr]);
              state_d = ST_BUSY;
            end
            OP_SAVE:
            begin
              if (wp_s)
                store_d[addr] = chan_q[ch];
              state_d = ST_BUSY;
            end
            OP_INC: chan_d[ch].wiper_position_reg = step(cur_wiper, 1'b1);
            OP_DEC: chan_d[ch].wiper_position_reg = step(cur_wiper, 1'b0);
            OP_SLEEP: asleep_d = 1'b1;
            OP_ERASE:
            begin
              if (wp_s)
                store_d[addr] = ERASED_WORD;
            end
            OP_SWRESET:
            begin
              asleep_d = 1'b1;
              state_d = ST_INIT;
            end
            default: ;
          endcase
        end
      end
      ST_BUSY:
      begin
        // Frames arriving while busy are dropped
        if (busy_q == BUSY_LAST)
          state_d = ST_IDLE;
        else
          busy_d = 16'(busy_q + 16'h0001);
      end
      default: state_d = ST_IDLE;
    endcase
    ready_d = (state_d == ST_IDLE);
  end

  // Stored words clear at power-up or by an erase command while wp_n is high; software reset keeps them
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= ST_INIT;
      asleep_q <= 1'b1;
      ready_q <= 1'b0;
      busy_q <= BUSY_RST;
      chan_q <= {4{CHAN_RST}};
      rdata_q <= READ_RST;
      for (int i = 0; i < 16; i++)
        store_q[i] <= ERASED_WORD;
    end
    else
    begin
      state_q <= state_d;
      asleep_q <= asleep_d;
      ready_q <= ready_d;
      busy_q <= busy_d;
      chan_q <= chan_d;
      rdata_q <= rdata_d;
      store_q <= store_d;
    end
  end

  assign spi_sdo = sdo_q;
  assign spi_sdo_oe = oe_q;
  assign ready_busy = ready_q;
  assign asleep = asleep_q;
  assign chan_out = chan_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_nop_keeps_state: assert property (exec && cmd.opcode_field == OP_NOP
    |=> $stable(chan_q) && $stable(asleep_q))
    else $error("nop changed state");
  a_write_loads_wiper: assert property (act && cmd.opcode_field == OP_WR_WIPER
    |=> chan_q[$past(ch)].wiper_position_reg == $past(cmd.wiper_value_bits))
    else $error("write lost");
  a_write_keeps_mode: assert property (act && cmd.opcode_field == OP_WR_WIPER
    |=> chan_q[$past(ch)].buffer_mode_bit == $past(chan_q[ch].buffer_mode_bit))
    else $error("mode changed");
  a_inc_saturates: assert property (act && cmd.opcode_field == OP_INC
    && cur_wiper == WIPER_MAX |=> chan_q[$past(ch)].wiper_position_reg == WIPER_MAX)
    else $error("increment wrapped");
  a_dec_one_step: assert property (act && cmd.opcode_field == OP_DEC
    && cur_wiper != WIPER_MIN
    |=> chan_q[$past(ch)].wiper_position_reg == 8'($past(cur_wiper) - 8'h01))
    else $error("decrement wrong");
  a_sleep_enters: assert property (act && cmd.opcode_field == OP_SLEEP
    |=> asleep_q ##1 asleep_q)
    else $error("sleep missed");
  a_asleep_ignores: assert property (exec && asleep_q && cmd.opcode_field != OP_WAKE
    |=> $stable(chan_q) && asleep_q)
    else $error("asleep acted");
  a_busy_after_read: assert property (act && cmd.opcode_field == OP_RD_STORE
    |=> !ready_busy [*2])
    else $error("busy missing");
  a_protect_store: assert property (act && cmd.opcode_field == OP_PROGRAM && !wp_s
    |=> store_q[$past(addr)] == $past(store_q[addr]))
    else $error("protected word written");
endmodule

// file: testbench/host_model.sv
// Host side of the four-wire serial link
`timescale 1ns/1ns
module host_model
  import wiper_pkg::*;
(
  input wire logic clk,
  input wire logic ready_busy,
  input wire logic spi_sdo,
  output logic spi_clk,
  output logic spi_cs_n,
  output logic spi_sdi
);
  int n;
  initial
  begin
    spi_clk = 1'b0;
    spi_cs_n = 1'b1;
    spi_sdi = 1'b0;
  end
  // Sends nb bits msb first; clock idles low between frames
  task automatic xfer(input logic [23:0] tx, input int nb, output logic [23:0] rx);
    n = 0;
    while (ready_busy !== 1'b1 && n < 500)
    begin
      @(posedge clk);
      #3;
      n++;
    end
    @(posedge clk);
    #3 spi_cs_n = 1'b0;
    #400;
    for (int i = 23; i > 23 - nb; i--)
    begin
      spi_sdi = tx[i];
      #400 spi_clk = 1'b1;
      rx[i] = spi_sdo;
      #400 spi_clk = 1'b0;
    end
    // Released line must not keep the last bit
    spi_sdi = ~spi_sdi;
    #800 spi_cs_n = 1'b1;
  endtask
endmodule

// file: testbench/tb.sv
// Self-checking bench for the quad wiper command decoder
`timescale 1ns/1ns
module tb
  import wiper_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic wp_n = 1'b1;
  logic spi_clk, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe, ready_busy, asleep;
  chan_t [3:0] chan_out;
  logic [23:0] rx;
  int miscompares = 0;
  int check_count = 0;
  int cyc = 0;
  always #50 clk = ~clk;
  // Short busy time keeps the run brief
  quad_wiper_command_decoder #(.BUSY_CYCLES(20)) DUT (
    .clk(clk),
    .nrst(nrst),
    .spi_clk(spi_clk),
    .spi_cs_n(spi_cs_n),
    .spi_sdi(spi_sdi),
    .wp_n(wp_n),
    .spi_sdo(spi_sdo),
    .spi_sdo_oe(spi_sdo_oe),
    .ready_busy(ready_busy),
    .asleep(asleep),
    .chan_out(chan_out)
  );
  host_model host (
    .clk(clk),
    .ready_busy(ready_busy),
    .spi_sdo(spi_sdo),
    .spi_clk(spi_clk),
    .spi_cs_n(spi_cs_n),
    .spi_sdi(spi_sdi)
  );
  task automatic finish_test();
    $display("Mismatches %0d of %0d checks", miscompares, check_count);
    if (miscompares == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp)
    begin
      $display("Error %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask
  task automatic cmd(input logic [3:0] op, input logic [3:0] a, input logic [8:0] d);
    host.xfer({op, a, 7'h00, d}, 24, rx);
    repeat (10) @(posedge clk);
    #3;
  endtask
  task automatic wip(input int c, input logic [8:0] e);
    chk({15'h0000, chan_out[c]}, {15'h0000, e});
  endtask
  task automatic slp(input logic e);
    chk({23'h000000, asleep}, {23'h000000, e});
  endtask
  // Read data only appears during the following frame
  task automatic rd(input logic [3:0] op, input logic [3:0] a, input logic [8:0] e);
    cmd(op, a, 9'h000);
    chk({23'h000000, ready_busy}, 24'h000000);
    chk({23'h000000, spi_sdo_oe}, 24'h000000);
    cmd(OP_NOP, 4'h0, 9'h000);
    chk(rx, {15'h0000, e});
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      finish_test();
    end
  end
  initial
  begin
    repeat (5) @(posedge clk);
    #3 nrst = 1'b1;
    repeat (8) @(posedge clk);
    #3;
    slp(1'b1);
    wip(0, 9'h000);
    cmd(OP_WR_WIPER, 4'h0, 9'h055);
    wip(0, 9'h000);
    cmd(OP_WAKE, 4'h0, 9'h000);
    slp(1'b0);
    cmd(OP_WR_WIPER, 4'h1, 9'h1fe);
    wip(1, 9'h0fe);
    cmd(OP_INC, 4'h1, 9'h000);
    wip(1, 9'h0ff);
    cmd(OP_INC, 4'h1, 9'h000);
    wip(1, 9'h0ff);
    cmd(OP_WR_WIPER, 4'h2, 9'h001);
    cmd(OP_DEC, 4'h2, 9'h000);
    wip(2, 9'h000);
    cmd(OP_DEC, 4'h2, 9'h000);
    wip(2, 9'h000);
    cmd(OP_NOP, 4'h1, 9'h033);
    cmd(4'h5, 4'h1, 9'h033);
    wip(1, 9'h0ff);
    host.xfer({OP_WR_WIPER, 4'h1, 16'h0033}, 23, rx);
    repeat (10) @(posedge clk);
    #3;
    wip(1, 9'h0ff);
    cmd(OP_PROGRAM, 4'h5, 9'h1a5);
    rd(OP_RD_STORE, 4'h5, 9'h1a5);
    cmd(OP_RESTORE, 4'h5, 9'h000);
    wip(1, 9'h1a5);
    cmd(OP_DEC, 4'h1, 9'h000);
    wip(1, 9'h1a4);
    rd(OP_RD_WIPER, 4'h1, 9'h1a4);
    cmd(OP_SAVE, 4'h9, 9'h0ff);
    rd(OP_RD_STORE, 4'h9, 9'h1a4);
    cmd(OP_ERASE, 4'h9, 9'h000);
    rd(OP_RD_STORE, 4'h9, 9'h000);
    wp_n = 1'b0;
    cmd(OP_PROGRAM, 4'hc, 9'h0ff);
    cmd(OP_SAVE, 4'h5, 9'h000);
    cmd(OP_ERASE, 4'h5, 9'h000);
    rd(OP_RD_STORE, 4'hc, 9'h000);
    rd(OP_RD_STORE, 4'h5, 9'h1a5);
    cmd(OP_RESTORE, 4'h5, 9'h000);
    wip(1, 9'h1a5);
    wp_n = 1'b1;
    cmd(OP_PROGRAM, 4'h3, 9'h033);
    cmd(OP_SWRESET, 4'h0, 9'h000);
    slp(1'b1);
    wip(3, 9'h033);
    wip(1, 9'h000);
    cmd(OP_WAKE, 4'h0, 9'h000);
    cmd(OP_SLEEP, 4'h0, 9'h000);
    slp(1'b1);
    cmd(OP_INC, 4'h3, 9'h000);
    wip(3, 9'h033);
    cmd(OP_WAKE, 4'h0, 9'h000);
    slp(1'b0);
    finish_test();
  end
endmodule
